// ### hdl/atsc_map.svh
/*
  register offsets, field positions, reset values and command codes of the
  task-file status and control block; include once from each design file
*/
`ifndef ATSC_MAP_SVH
`define ATSC_MAP_SVH

// ----------------------------------------------------------------------
// task-file offsets
// ----------------------------------------------------------------------
`define ATSC_OFF_FEATURE    4'h1
`define ATSC_OFF_CYL_LO     4'h4
`define ATSC_OFF_CYL_HI     4'h5
`define ATSC_OFF_DRV_HEAD   4'h6
`define ATSC_OFF_STATUS     4'h7
`define ATSC_OFF_ALT_STATUS 4'he
`define ATSC_OFF_DEV_CTRL   4'he
`define ATSC_OFF_DRIVE_ADDR 4'hf

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ATSC_STS_BUSY     7
`define ATSC_STS_READY    6
`define ATSC_STS_WFAULT   5
`define ATSC_STS_SEEK     4
`define ATSC_STS_XFER     3
`define ATSC_STS_CORRECTED_DATA_FLAG     2
`define ATSC_STS_INDEX    1
`define ATSC_STS_ERROR    0
`define ATSC_CTL_SRST     2
`define ATSC_CTL_IEN_N    1
`define ATSC_DH_LBA       6
`define ATSC_DH_DRV       4
`define ATSC_DA_WTG_N     6

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ATSC_RST_DRV_HEAD 8'ha0
`define ATSC_RST_BYTE     8'h00

// ----------------------------------------------------------------------
// health-monitoring subcommands and signature
// ----------------------------------------------------------------------
`define ATSC_SC_READ_DATA   8'hd0
`define ATSC_SC_READ_THRESH 8'hd1
`define ATSC_SC_AUTOSAVE    8'hd2
`define ATSC_SC_READ_LOG    8'hd5
`define ATSC_SC_WRITE_LOG   8'hd6
`define ATSC_SC_ENABLE      8'hd8
`define ATSC_SC_DISABLE     8'hd9
`define ATSC_SC_RET_STATUS  8'hda
`define ATSC_SIG_CYL_LO     8'h4f
`define ATSC_SIG_CYL_HI     8'hc2

`endif

// ### hdl/atsc_pkg.sv
/*
  types shared by the status and control block and its helpers;
  assumes nothing of its surroundings
*/
package atsc_pkg;

  typedef enum logic [3:0] {
    SMART_NONE, SMART_READ_DATA, SMART_READ_THRESH, SMART_AUTOSAVE,
    SMART_READ_LOG, SMART_WRITE_LOG, SMART_ENABLE, SMART_DISABLE,
    SMART_RET_STATUS
  } atsc_smart_t;

  typedef struct packed {
    logic busy;
    logic ready;
    logic write_fault;
    logic seek_complete;
    logic xfer_request;
    logic corrected;
    logic cmd_error;
  } atsc_core_sts_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } atsc_tf_req_t;

endpackage : atsc_pkg

// ### hdl/atsc_smart_dec.sv
/*
  decoder of the health-monitoring subcommand byte held in the feature
  register; purely combinational, the caller registers the result
*/
`timescale 1ns/10ps
`include "atsc_map.svh"

module atsc_smart_dec (
  input wire logic [7:0] feature,
  output atsc_pkg::atsc_smart_t cmd
);
  import atsc_pkg::*;

  always_comb begin
    case (feature)
      `ATSC_SC_READ_DATA:   cmd = SMART_READ_DATA;
      `ATSC_SC_READ_THRESH: cmd = SMART_READ_THRESH;
      `ATSC_SC_AUTOSAVE:    cmd = SMART_AUTOSAVE;
      `ATSC_SC_READ_LOG:    cmd = SMART_READ_LOG;
      `ATSC_SC_WRITE_LOG:   cmd = SMART_WRITE_LOG;
      `ATSC_SC_ENABLE:      cmd = SMART_ENABLE;
      `ATSC_SC_DISABLE:     cmd = SMART_DISABLE;
      `ATSC_SC_RET_STATUS:  cmd = SMART_RET_STATUS;
      default:              cmd = SMART_NONE;
    endcase
  end

endmodule : atsc_smart_dec

// ### hdl/atsc_drive_readback.sv
/*
  builds the legacy drive address readback byte from the drive/head
  register and the core's write activity; combinational
*/
`timescale 1ns/10ps
`include "atsc_map.svh"

module atsc_drive_readback (
  input wire logic [7:0] drive_head,
  input wire logic write_active,
  input wire logic drive_present,
  output logic [7:0] readback
);

  logic drv_bit;

  assign drv_bit = drive_head[`ATSC_DH_DRV];

  always_comb begin
    // top bit has no defined meaning; zero keeps it from fighting the bus
    readback[7] = 1'b0;
    readback[`ATSC_DA_WTG_N] = ~write_active;
    readback[5:2] = ~drive_head[3:0];
    readback[1] = ~(drive_present & drv_bit);
    readback[0] = ~(drive_present & ~drv_bit);
  end

endmodule : atsc_drive_readback

// ### hdl/atsc_regs.sv
/*
  task-file status and control registers: status and alternate status,
  device control, drive address readback and subcommand decode.
  assumes a host port already decoded to a 4-bit offset with single-cycle
  read and write strobes, and a device core that reports its state levels.
*/
// Overview of operation
// - status and alternate both return status; only primary read clears interrupt
// - busy bit 7 set while device owns buffers; other bits invalid then
// - ready bit 6 held low from power-up until commands can be accepted
// - data request bit 3 set whenever a data-register word transfer is needed
// - corrected bit 2 set after a fixed error; multi-sector read continues
// - status bit 1 always reads zero
// - error bit 0 set when previous command failed; details in error register
// - device control writes ignore bits 7 to 3 and bit 0
// - soft reset bit 2 holds controller in reset until written back to zero
// - bit 1 zero enables interrupts, one suppresses; also drives config interrupt bit
// - interrupt disable bit cleared at power-on and reset
// - readback bit 6 is zero during a write, one otherwise
// - readback bits 5 to 2 are inverted head-select bits 3 to 0
// - readback bits 1 and 0 low show drive 1 or drive 0 selected
// - readback bit 7 is undefined; hosts should avoid mapping that register
// - feature register codes select health-monitoring subcommands
// - head-select bits are head number in CHS, address bits 27 to 24 in LBA
`timescale 1ns/10ps
`include "atsc_map.svh"

module atsc_regs #(
  parameter logic [7:0] SMART_OPCODE = 8'hb0
) (
  input wire logic clk,
  input wire logic rst,
  input wire atsc_pkg::atsc_tf_req_t tf_req,
  input wire atsc_pkg::atsc_core_sts_t core_sts,
  input wire logic irq_event,
  input wire logic write_active,
  input wire logic drive_present,
  output logic [7:0] rdata_r,
  output logic irq_r,
  output logic soft_reset_r,
  output logic int_disable_n_r,
  output logic lba_mode_r,
  output logic [3:0] head_lba_hi_r,
  output logic smart_valid_r,
  output logic smart_reject_r,
  output atsc_pkg::atsc_smart_t smart_cmd_r
);
  import atsc_pkg::*;

  // ----------------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------------
  logic [7:0] drive_head_r;
  logic [7:0] drive_head_nxt;
  logic [7:0] feature_r;
  logic [7:0] feature_nxt;
  logic [7:0] cyl_lo_r;
  logic [7:0] cyl_lo_nxt;
  logic [7:0] cyl_hi_r;
  logic [7:0] cyl_hi_nxt;
  logic irq_pend_r;
  logic irq_pend_nxt;
  logic [7:0] rdata_nxt;
  logic irq_nxt;
  logic soft_reset_nxt;
  logic int_disable_n_nxt;
  logic smart_valid_nxt;
  logic smart_reject_nxt;
  atsc_smart_t smart_cmd_nxt;

  logic [7:0] sts_byte;
  logic [7:0] drive_addr_byte;
  atsc_smart_t dec_cmd;
  logic rd_status;
  logic rd_alt;
  logic wr_ctrl;
  logic wr_taskfile;
  logic sig_ok;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  atsc_smart_dec u_dec (
    .feature(feature_r),
    .cmd(dec_cmd)
  );

  atsc_drive_readback u_rb (
    .drive_head(drive_head_r),
    .write_active(write_active),
    .drive_present(drive_present),
    .readback(drive_addr_byte)
  );

  // ----------------------------------------------------------------------
  // status byte
  // ----------------------------------------------------------------------
  always_comb begin
    sts_byte = `ATSC_RST_BYTE;
    sts_byte[`ATSC_STS_BUSY] = core_sts.busy;
    sts_byte[`ATSC_STS_READY] = core_sts.ready;
    sts_byte[`ATSC_STS_WFAULT] = core_sts.write_fault;
    sts_byte[`ATSC_STS_SEEK] = core_sts.seek_complete;
    sts_byte[`ATSC_STS_XFER] = core_sts.xfer_request;
    sts_byte[`ATSC_STS_CORRECTED_DATA_FLAG] = core_sts.corrected;
    sts_byte[`ATSC_STS_INDEX] = 1'b0;
    sts_byte[`ATSC_STS_ERROR] = core_sts.cmd_error;
  end

  // ----------------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------------
  assign rd_status = tf_req.rd && (tf_req.addr == `ATSC_OFF_STATUS);
  assign rd_alt = tf_req.rd && (tf_req.addr == `ATSC_OFF_ALT_STATUS);
  assign wr_ctrl = tf_req.wr && (tf_req.addr == `ATSC_OFF_DEV_CTRL);
  // host writes to the task file, except device control, are dropped while busy or in soft reset; reads are still answered
  assign wr_taskfile = tf_req.wr && !core_sts.busy && !soft_reset_r;
  assign sig_ok = (cyl_lo_r == `ATSC_SIG_CYL_LO) && (cyl_hi_r == `ATSC_SIG_CYL_HI);

  // ----------------------------------------------------------------------
  // next-value logic
  // ----------------------------------------------------------------------
  always_comb begin
    drive_head_nxt = drive_head_r;
    feature_nxt = feature_r;
    cyl_lo_nxt = cyl_lo_r;
    cyl_hi_nxt = cyl_hi_r;
    irq_pend_nxt = irq_pend_r;
    rdata_nxt = rdata_r;
    soft_reset_nxt = soft_reset_r;
    int_disable_n_nxt = int_disable_n_r;
    smart_valid_nxt = 1'b0;
    smart_reject_nxt = 1'b0;
    smart_cmd_nxt = smart_cmd_r;

    if (wr_taskfile) begin
      case (tf_req.addr)
        `ATSC_OFF_FEATURE: feature_nxt = tf_req.wdata;
        `ATSC_OFF_CYL_LO: cyl_lo_nxt = tf_req.wdata;
        `ATSC_OFF_CYL_HI: cyl_hi_nxt = tf_req.wdata;
        `ATSC_OFF_DRV_HEAD: drive_head_nxt = tf_req.wdata;
        `ATSC_OFF_STATUS: begin
          if (tf_req.wdata == SMART_OPCODE) begin
            // without the signature, or with an unknown subcommand, the command is not issued; only the reject pulse fires
            if (sig_ok && dec_cmd != SMART_NONE) begin
              smart_valid_nxt = 1'b1;
              smart_cmd_nxt = dec_cmd;
            end else begin
              smart_reject_nxt = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // only the two live bits are kept; the rest of the byte is dropped
    if (wr_ctrl) begin
      soft_reset_nxt = tf_req.wdata[`ATSC_CTL_SRST];
      int_disable_n_nxt = tf_req.wdata[`ATSC_CTL_IEN_N];
    end

    // event wins over a same-cycle clear by a primary status read
    if (rd_status) begin
      irq_pend_nxt = 1'b0;
    end
    if (soft_reset_r) begin
      irq_pend_nxt = 1'b0;
    end
    if (irq_event && !soft_reset_r) begin
      irq_pend_nxt = 1'b1;
    end

    irq_nxt = irq_pend_r && !int_disable_n_r;

    if (tf_req.rd) begin
      case (tf_req.addr)
        `ATSC_OFF_STATUS: rdata_nxt = sts_byte;
        `ATSC_OFF_ALT_STATUS: rdata_nxt = sts_byte;
        `ATSC_OFF_DRIVE_ADDR: rdata_nxt = drive_addr_byte;
        `ATSC_OFF_CYL_LO: rdata_nxt = cyl_lo_r;
        `ATSC_OFF_CYL_HI: rdata_nxt = cyl_hi_r;
        `ATSC_OFF_DRV_HEAD: rdata_nxt = drive_head_r;
        default: rdata_nxt = `ATSC_RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_head_r <= `ATSC_RST_DRV_HEAD;
      feature_r <= `ATSC_RST_BYTE;
      cyl_lo_r <= `ATSC_RST_BYTE;
      cyl_hi_r <= `ATSC_RST_BYTE;
      irq_pend_r <= 1'b0;
      rdata_r <= `ATSC_RST_BYTE;
      irq_r <= 1'b0;
      soft_reset_r <= 1'b0;
      int_disable_n_r <= 1'b0;
      lba_mode_r <= 1'b0;
      head_lba_hi_r <= 4'h0;
      smart_valid_r <= 1'b0;
      smart_reject_r <= 1'b0;
      smart_cmd_r <= SMART_NONE;
    end else begin
      drive_head_r <= drive_head_nxt;
      feature_r <= feature_nxt;
      cyl_lo_r <= cyl_lo_nxt;
      cyl_hi_r <= cyl_hi_nxt;
      irq_pend_r <= irq_pend_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      soft_reset_r <= soft_reset_nxt;
      int_disable_n_r <= int_disable_n_nxt;
      lba_mode_r <= drive_head_nxt[`ATSC_DH_LBA];
      head_lba_hi_r <= drive_head_nxt[3:0];
      smart_valid_r <= smart_valid_nxt;
      smart_reject_r <= smart_reject_nxt;
      smart_cmd_r <= smart_cmd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_status_read_clears;
    rd_status && !irq_event && !tf_req.wr |=> !irq_pend_r ##1 !irq_r;
  endproperty
  a_status_read_clears: assert property (p_status_read_clears)
    else $error("primary status read did not clear interrupt");

  property p_alt_read_keeps;
    rd_alt && irq_pend_r && !soft_reset_r |=> irq_pend_r;
  endproperty
  a_alt_read_keeps: assert property (p_alt_read_keeps)
    else $error("alternate status read cleared interrupt");

  property p_alt_equals_status;
    rd_alt |=> rdata_r == $past(sts_byte);
  endproperty
  a_alt_equals_status: assert property (p_alt_equals_status)
    else $error("alternate status differs from status");

  property p_busy_ready_bits;
    rd_status |=> rdata_r[7] == $past(core_sts.busy) && rdata_r[6] == $past(core_sts.ready);
  endproperty
  a_busy_ready_bits: assert property (p_busy_ready_bits)
    else $error("busy or ready bit wrong in status");

  property p_index_zero;
    (rd_status || rd_alt) |=> !rdata_r[1] && rdata_r[0] == $past(core_sts.cmd_error);
  endproperty
  a_index_zero: assert property (p_index_zero)
    else $error("index bit or error bit wrong");

  property p_soft_reset_holds;
    soft_reset_r && !wr_ctrl |=> soft_reset_r;
  endproperty
  a_soft_reset_holds: assert property (p_soft_reset_holds)
    else $error("soft reset released without a control write");

  property p_ctrl_write;
    wr_ctrl |=> soft_reset_r == $past(tf_req.wdata[2]) &&
      int_disable_n_r == $past(tf_req.wdata[1]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("device control bits not taken");

  property p_irq_masked;
    int_disable_n_r |=> !irq_r;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised while disabled");

  property p_readback;
    tf_req.rd && tf_req.addr == `ATSC_OFF_DRIVE_ADDR |=>
      rdata_r[6] == !$past(write_active) && rdata_r[5:2] == ~$past(drive_head_r[3:0]);
  endproperty
  a_readback: assert property (p_readback)
    else $error("drive readback byte wrong");

  property p_smart_needs_sig;
    smart_valid_r |-> $past(sig_ok) && smart_cmd_r != SMART_NONE;
  endproperty
  a_smart_needs_sig: assert property (p_smart_needs_sig)
    else $error("subcommand issued without signature");

  c_irq_cleared: cover property (irq_r ##1 rd_status ##2 !irq_r);
  c_soft_reset: cover property ($rose(soft_reset_r) ##[1:20] $fell(soft_reset_r));
  c_smart_issue: cover property (smart_valid_r && smart_cmd_r == SMART_RET_STATUS);

endmodule : atsc_regs

// ### test/atsc_host_model.sv
/*
  behavioural host controller that drives the task-file strobes of the
  status and control block; assumes the block samples on the rising edge
  of clk and answers reads one cycle after the read strobe is taken
*/
`timescale 1ns/10ps
`include "atsc_map.svh"

module atsc_host_model (
  input wire logic clk,
  output atsc_pkg::atsc_tf_req_t tf_req,
  input wire logic [7:0] rdata_r
);
  import atsc_pkg::*;

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  // after each cycle the idle address, and after a write the data, are inverted so that nothing can lean on a stale value
  initial tf_req = '{rd: 1'b0, wr: 1'b0, addr: 4'h0, wdata: 8'h00};

  // the bench maps the readback location, so it may use what it returns
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    tf_req.rd = 1'b1;
    tf_req.addr = a;
    @(negedge clk);
    tf_req.rd = 1'b0;
    tf_req.addr = ~a;
    d = rdata_r;
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    tf_req.wr = 1'b1;
    tf_req.addr = a;
    tf_req.wdata = d;
    @(negedge clk);
    tf_req.wr = 1'b0;
    tf_req.addr = ~a;
    tf_req.wdata = ~d;
  endtask : wr

  // ----------------------------------------------------------------------
  // subcommand issue
  // ----------------------------------------------------------------------
  // signature goes in first; a caller passes a wrong one only on purpose
  task automatic smart(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
    wr(`ATSC_OFF_CYL_LO, lo);
    wr(`ATSC_OFF_CYL_HI, hi);
    wr(`ATSC_OFF_FEATURE, code);
    wr(`ATSC_OFF_STATUS, 8'hb0);
  endtask : smart

endmodule : atsc_host_model

// ### test/tb.sv
/*
  self-checking bench of the status and control registers; the host model
  issues task-file cycles and the bench plays the device core directly
*/
`timescale 1ns/10ps
`include "atsc_map.svh"

module tb;
  import atsc_pkg::*;

  // ----------------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  atsc_tf_req_t tf_req;
  atsc_core_sts_t core_sts = '0;
  logic irq_event = 1'b0;
  logic write_active = 1'b0;
  logic drive_present = 1'b1;
  logic [7:0] rdata_r;
  logic irq_r, soft_reset_r, int_disable_n_r, lba_mode_r, smart_valid_r, smart_reject_r;
  logic [3:0] head_lba_hi_r;
  atsc_smart_t smart_cmd_r;
  logic [7:0] d, e;
  int err_total = 0;
  int n_compared = 0;
  logic [6:0] sts_tab [6] = '{7'h3f, 7'h00, 7'h2a, 7'h15, 7'h01, 7'h20};
  logic [7:0] dh_tab [4] = '{8'he5, 8'hf0, 8'hba, 8'ha3};
  logic [7:0] sc_code [8] = '{8'hd0, 8'hd1, 8'hd2, 8'hd5, 8'hd6, 8'hd8, 8'hd9, 8'hda};
  atsc_smart_t sc_exp [8] = '{SMART_READ_DATA, SMART_READ_THRESH, SMART_AUTOSAVE,
    SMART_READ_LOG, SMART_WRITE_LOG, SMART_ENABLE, SMART_DISABLE, SMART_RET_STATUS};

  always #20 clk = ~clk;

  atsc_regs i_dut (.clk(clk), .rst(rst), .tf_req(tf_req), .core_sts(core_sts),
    .irq_event(irq_event), .write_active(write_active), .drive_present(drive_present),
    .rdata_r(rdata_r), .irq_r(irq_r), .soft_reset_r(soft_reset_r),
    .int_disable_n_r(int_disable_n_r), .lba_mode_r(lba_mode_r),
    .head_lba_hi_r(head_lba_hi_r), .smart_valid_r(smart_valid_r),
    .smart_reject_r(smart_reject_r), .smart_cmd_r(smart_cmd_r));

  atsc_host_model i_host (.clk(clk), .tf_req(tf_req), .rdata_r(rdata_r));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] rb(input logic [7:0] dh, input logic wa, input logic dp);
    rb = {1'b0, ~wa, ~dh[3:0], ~(dp & dh[4]), ~(dp & ~dh[4])};
  endfunction : rb

  // event pulse, then one more cycle for the registered request to show
  task automatic irq_pulse();
    @(negedge clk);
    irq_event = 1'b1;
    @(negedge clk);
    irq_event = 1'b0;
    @(negedge clk);
  endtask : irq_pulse

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    #400000;
    err_total++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk("int_disable_n", 8'h00, {7'h00, int_disable_n_r});
    chk("soft_reset", 8'h00, {7'h00, soft_reset_r});
    chk("smart_cmd", {4'h0, SMART_NONE}, {4'h0, smart_cmd_r});
    i_host.rd(`ATSC_OFF_DRIVE_ADDR, d);
    chk("readback reset", rb(8'ha0, 1'b0, 1'b1), d);
    i_host.rd(4'h2, d);
    chk("unmapped read", 8'h00, d);
    foreach (sts_tab[i]) begin
      @(negedge clk);
      core_sts = sts_tab[i];
      e = {sts_tab[i][6:1], 1'b0, sts_tab[i][0]};
      i_host.rd(`ATSC_OFF_STATUS, d);
      chk("status", e, d);
      i_host.rd(`ATSC_OFF_ALT_STATUS, d);
      chk("alt status", e, d);
    end
    // with busy up only bit 7 means anything; writes to the drive/head must bounce
    @(negedge clk);
    core_sts = 7'h55;
    i_host.rd(`ATSC_OFF_STATUS, d);
    chk("busy bit", 8'h80, d & 8'h80);
    i_host.wr(`ATSC_OFF_DRV_HEAD, 8'he5);
    i_host.rd(`ATSC_OFF_DRV_HEAD, d);
    chk("busy refusal", 8'ha0, d);
    @(negedge clk);
    core_sts = '0;
    foreach (dh_tab[i]) begin
      i_host.wr(`ATSC_OFF_DRV_HEAD, dh_tab[i]);
      write_active = dh_tab[i][0];
      drive_present = ~dh_tab[i][3];
      i_host.rd(`ATSC_OFF_DRIVE_ADDR, d);
      chk("readback", rb(dh_tab[i], dh_tab[i][0], ~dh_tab[i][3]), d);
      chk("lba mode", {7'h00, dh_tab[i][6]}, {7'h00, lba_mode_r});
      chk("head bits", {4'h0, dh_tab[i][3:0]}, {4'h0, head_lba_hi_r});
    end
    drive_present = 1'b1;
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'hff);
    chk("ctl ff", 8'h03, {6'h00, soft_reset_r, int_disable_n_r});
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'hf9);
    chk("ctl f9", 8'h00, {6'h00, soft_reset_r, int_disable_n_r});
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'h0b);
    chk("ctl 0b", 8'h01, {6'h00, soft_reset_r, int_disable_n_r});
    irq_pulse();
    chk("irq masked", 8'h00, {7'h00, irq_r});
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'h00);
    i_host.rd(`ATSC_OFF_STATUS, d);
    @(negedge clk);
    irq_pulse();
    chk("irq raised", 8'h01, {7'h00, irq_r});
    i_host.rd(`ATSC_OFF_ALT_STATUS, d);
    @(negedge clk);
    chk("irq after alt read", 8'h01, {7'h00, irq_r});
    i_host.rd(`ATSC_OFF_STATUS, d);
    @(negedge clk);
    chk("irq after status read", 8'h00, {7'h00, irq_r});
    // soft reset drops the pending request; the same write also sets the mask bit
    irq_pulse();
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'h06);
    @(negedge clk);
    chk("soft reset", 8'h03, {6'h00, soft_reset_r, int_disable_n_r});
    chk("irq in soft reset", 8'h00, {7'h00, irq_r});
    i_host.wr(`ATSC_OFF_DRV_HEAD, 8'hb5);
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'h00);
    chk("soft reset off", 8'h00, {7'h00, soft_reset_r});
    i_host.rd(`ATSC_OFF_DRV_HEAD, d);
    chk("write blocked in soft reset", 8'ha3, d);
    foreach (sc_code[i]) begin
      i_host.smart(sc_code[i], 8'h4f, 8'hc2);
      chk("smart valid", 8'h01, {7'h00, smart_valid_r});
      chk("smart cmd", {4'h0, sc_exp[i]}, {4'h0, smart_cmd_r});
    end
    i_host.smart(8'hd0, 8'h4f, 8'hc3);
    chk("bad signature", 8'h02, {6'h00, smart_reject_r, smart_valid_r});
    i_host.smart(8'hd3, 8'h4f, 8'hc2);
    chk("unknown feature", 8'h02, {6'h00, smart_reject_r, smart_valid_r});
    chk("smart cmd kept", {4'h0, SMART_RET_STATUS}, {4'h0, smart_cmd_r});
    i_host.wr(`ATSC_OFF_DEV_CTRL, 8'h02);
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk("int_disable_n after reset", 8'h00, {7'h00, int_disable_n_r});
    i_host.rd(`ATSC_OFF_DRV_HEAD, d);
    chk("drive head after reset", 8'ha0, d);
    wrap_up();
  end

endmodule : tb
